/* File: core/rsc_pkg.sv */
package rsc_pkg;
   // Delays counted in crystal periods; the core clock is the crystal clock.
   localparam int CRYSTAL_OSCILLATOR_PER_CLK = 1;
   localparam int ON_CRYSTAL_OSCILLATOR = 2298;
   localparam int TX2RX_CRYSTAL_OSCILLATOR = 560;
   localparam int RX2TX_CRYSTAL_OSCILLATOR = 250;
   localparam int OFF_CRYSTAL_OSCILLATOR = 2;
   localparam int ON_CYC = ON_CRYSTAL_OSCILLATOR / CRYSTAL_OSCILLATOR_PER_CLK;
   localparam int TX2RX_CYC = TX2RX_CRYSTAL_OSCILLATOR / CRYSTAL_OSCILLATOR_PER_CLK;
   localparam int RX2TX_CYC = RX2TX_CRYSTAL_OSCILLATOR / CRYSTAL_OSCILLATOR_PER_CLK;
   localparam int OFF_CYC = OFF_CRYSTAL_OSCILLATOR / CRYSTAL_OSCILLATOR_PER_CLK;
   localparam int CNT_W = 15;
   // Strobe register codes.
   localparam logic [7:0] STB_RECEIVE = 8'h01;
   localparam logic [7:0] STB_TRANSMIT = 8'h02;
   localparam logic [7:0] STB_SYNTH_ON = 8'h03;
   localparam logic [7:0] STB_GO_IDLE = 8'h04;
   localparam logic [7:0] STB_CALIBRATE = 8'h05;
   // Field encodings.
   localparam logic [1:0] OFF_IDLE = 2'h0;
   localparam logic [1:0] OFF_SYNTH = 2'h1;
   localparam logic [1:0] OFF_TX = 2'h2;
   localparam logic [1:0] OFF_RX = 2'h3;
   localparam logic [1:0] CAL_NEVER = 2'h0;
   localparam logic [1:0] CAL_ON_START = 2'h1;
   localparam logic [1:0] CAL_ON_STOP = 2'h2;
   localparam logic [1:0] CAL_FOURTH = 2'h3;
   localparam logic [1:0] CCA_ALWAYS = 2'h0;
   localparam logic [1:0] CCA_RSSI = 2'h1;
   localparam logic [1:0] CCA_NO_PKT = 2'h2;
   localparam logic [1:0] CCA_BOTH = 2'h3;
   localparam logic [1:0] FOURTH_LAST = 2'h3;
   // Readback codes.
   localparam logic [4:0] CODE_IDLE = 5'h01;
   localparam logic [4:0] CODE_START = 5'h04;
   localparam logic [4:0] CODE_CAL = 5'h08;
   localparam logic [4:0] CODE_STOP = 5'h0c;
   localparam logic [4:0] CODE_RX = 5'h0d;
   localparam logic [4:0] CODE_SYNTH = 5'h12;
   localparam logic [4:0] CODE_TX = 5'h13;
   localparam logic [4:0] CODE_TURN = 5'h14;
   typedef enum logic [2:0] {
      RSC_IDLE, RSC_WAIT, RSC_RX, RSC_TX, RSC_SYNTH
   } rsc_state_t;
   typedef struct packed {
      logic [1:0] synth_autocal_select;
      logic [1:0] after_receive_state;
      logic [1:0] after_transmit_state;
      logic [1:0] clear_channel_mode;
   } rsc_cfg_t;
   typedef struct packed {
      logic pkt_received;
      logic pkt_sent;
      logic rx_timeout;
      logic rssi_below;
      logic receiving;
   } rsc_stat_t;
endpackage : rsc_pkg

/* File: core/rsc_ctrl.sv */
`timescale 1ns/1ps
module rsc_ctrl #(
   parameter int CAL_CRYSTAL_OSCILLATOR = 18739,
   parameter int ON_CAL_CRYSTAL_OSCILLATOR = 21037
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_strobe_valid,
   input wire logic [7:0] i_radio_strobe_register,
   input wire rsc_pkg::rsc_cfg_t i_cfg,
   input wire rsc_pkg::rsc_stat_t i_stat,
   output logic [4:0] o_radio_state_readback,
   output logic o_rx_on,
   output logic o_tx_on,
   output logic o_synth_on,
   output logic o_cal_busy
);
   localparam int CAL_CYC = CAL_CRYSTAL_OSCILLATOR / rsc_pkg::CRYSTAL_OSCILLATOR_PER_CLK;
   localparam int ON_CAL_CYC = ON_CAL_CRYSTAL_OSCILLATOR / rsc_pkg::CRYSTAL_OSCILLATOR_PER_CLK;
   localparam logic [14:0] CNT_ONE = 15'h0001;

   rsc_pkg::rsc_state_t state_ff, nxt_state;
   rsc_pkg::rsc_state_t dest_ff, nxt_dest;
   logic [rsc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [4:0] code_ff, nxt_code;
   logic [1:0] fourth_ff, nxt_fourth;
   logic cal_ff, nxt_cal;
   logic s_rx, s_tx, s_syn, s_idle, s_cal, cca_ok;
   logic stop_cal;

   // Strobe decode; the strobe comes from the CPU in this clock domain.
   assign s_rx = i_strobe_valid &&
                 i_radio_strobe_register == rsc_pkg::STB_RECEIVE;
   assign s_tx = i_strobe_valid &&
                 i_radio_strobe_register == rsc_pkg::STB_TRANSMIT;
   assign s_syn = i_strobe_valid &&
                  i_radio_strobe_register == rsc_pkg::STB_SYNTH_ON;
   assign s_idle = i_strobe_valid &&
                   i_radio_strobe_register == rsc_pkg::STB_GO_IDLE;
   assign s_cal = i_strobe_valid &&
                  i_radio_strobe_register == rsc_pkg::STB_CALIBRATE;

   // Clear-channel qualifier for the transmit and synth-on strobes that leave receive.
   always_comb begin
      case (i_cfg.clear_channel_mode)
         rsc_pkg::CCA_ALWAYS: cca_ok = 1'b1;
         rsc_pkg::CCA_RSSI: cca_ok = i_stat.rssi_below;
         rsc_pkg::CCA_NO_PKT: cca_ok = !i_stat.receiving;
         default: cca_ok = i_stat.rssi_below && !i_stat.receiving;
      endcase
   end

   // Calibration on the way down: always, or on every fourth stop.
   assign stop_cal =
      i_cfg.synth_autocal_select == rsc_pkg::CAL_ON_STOP ||
      (i_cfg.synth_autocal_select == rsc_pkg::CAL_FOURTH &&
       fourth_ff == rsc_pkg::FOURTH_LAST);

   // Next-state logic. Every timed move goes through the wait state, which
   // holds a down counter and the destination; the idle strobe beats all.
   always_comb begin
      logic go_stop;
      logic [1:0] off_sel;
      logic go_off;
      go_stop = 1'b0;
      off_sel = rsc_pkg::OFF_IDLE;
      go_off = 1'b0;
      nxt_state = state_ff;
      nxt_dest = dest_ff;
      nxt_cnt = cnt_ff;
      nxt_code = code_ff;
      nxt_fourth = fourth_ff;
      nxt_cal = cal_ff;
      case (state_ff)
         rsc_pkg::RSC_IDLE: begin
            if (s_rx || s_tx || s_syn) begin
               nxt_state = rsc_pkg::RSC_WAIT;
               nxt_dest = s_rx ? rsc_pkg::RSC_RX :
                          s_tx ? rsc_pkg::RSC_TX : rsc_pkg::RSC_SYNTH;
               nxt_code = rsc_pkg::CODE_START;
               nxt_cal = i_cfg.synth_autocal_select ==
                         rsc_pkg::CAL_ON_START;
               nxt_cnt = nxt_cal ? CNT_ONE * ON_CAL_CYC[14:0]
                                 : rsc_pkg::ON_CYC[14:0];
            end else if (s_cal) begin
               nxt_state = rsc_pkg::RSC_WAIT;
               nxt_dest = rsc_pkg::RSC_IDLE;
               nxt_code = rsc_pkg::CODE_CAL;
               nxt_cal = 1'b1;
               nxt_cnt = CAL_CYC[14:0];
            end
         end
         rsc_pkg::RSC_WAIT: begin
            if (s_idle) begin
               nxt_state = rsc_pkg::RSC_IDLE;
               nxt_code = rsc_pkg::CODE_IDLE;
               nxt_cal = 1'b0;
            end else if (cnt_ff == CNT_ONE) begin
               nxt_state = dest_ff;
               nxt_cal = 1'b0;
               case (dest_ff)
                  rsc_pkg::RSC_RX: nxt_code = rsc_pkg::CODE_RX;
                  rsc_pkg::RSC_TX: nxt_code = rsc_pkg::CODE_TX;
                  rsc_pkg::RSC_SYNTH: nxt_code = rsc_pkg::CODE_SYNTH;
                  default: nxt_code = rsc_pkg::CODE_IDLE;
               endcase
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         rsc_pkg::RSC_RX: begin
            if (s_idle) begin
               go_stop = 1'b1;
            end else if ((s_tx || s_syn) && cca_ok) begin
               nxt_state = rsc_pkg::RSC_WAIT;
               nxt_dest = s_tx ? rsc_pkg::RSC_TX : rsc_pkg::RSC_SYNTH;
               nxt_code = rsc_pkg::CODE_TURN;
               nxt_cnt = rsc_pkg::RX2TX_CYC[14:0];
            end else if (i_stat.pkt_received) begin
               go_off = 1'b1;
               off_sel = i_cfg.after_receive_state;
            end else if (i_stat.rx_timeout) begin
               go_stop = 1'b1;
            end
         end
         rsc_pkg::RSC_TX: begin
            if (s_idle) begin
               go_stop = 1'b1;
            end else if (s_rx) begin
               nxt_state = rsc_pkg::RSC_WAIT;
               nxt_dest = rsc_pkg::RSC_RX;
               nxt_code = rsc_pkg::CODE_TURN;
               nxt_cnt = rsc_pkg::TX2RX_CYC[14:0];
            end else if (i_stat.pkt_sent) begin
               go_off = 1'b1;
               off_sel = i_cfg.after_transmit_state;
            end
         end
         rsc_pkg::RSC_SYNTH: begin
            if (s_idle) begin
               nxt_state = rsc_pkg::RSC_IDLE;
               nxt_code = rsc_pkg::CODE_IDLE;
            end else if (s_tx) begin
               nxt_state = rsc_pkg::RSC_TX;
               nxt_code = rsc_pkg::CODE_TX;
            end
         end
         default: begin
            nxt_state = rsc_pkg::RSC_IDLE;
            nxt_code = rsc_pkg::CODE_IDLE;
         end
      endcase
      // After-packet destination, shared by receive and transmit.
      if (go_off) begin
         case (off_sel)
            rsc_pkg::OFF_IDLE: go_stop = 1'b1;
            rsc_pkg::OFF_SYNTH: begin
               if (state_ff == rsc_pkg::RSC_RX) begin
                  nxt_state = rsc_pkg::RSC_WAIT;
                  nxt_dest = rsc_pkg::RSC_SYNTH;
                  nxt_code = rsc_pkg::CODE_TURN;
                  nxt_cnt = rsc_pkg::RX2TX_CYC[14:0];
               end else begin
                  nxt_state = rsc_pkg::RSC_SYNTH;
                  nxt_code = rsc_pkg::CODE_SYNTH;
               end
            end
            rsc_pkg::OFF_TX: begin
               if (state_ff == rsc_pkg::RSC_RX) begin
                  nxt_state = rsc_pkg::RSC_WAIT;
                  nxt_dest = rsc_pkg::RSC_TX;
                  nxt_code = rsc_pkg::CODE_TURN;
                  nxt_cnt = rsc_pkg::RX2TX_CYC[14:0];
               end
            end
            default: begin
               if (state_ff == rsc_pkg::RSC_TX) begin
                  nxt_state = rsc_pkg::RSC_WAIT;
                  nxt_dest = rsc_pkg::RSC_RX;
                  nxt_code = rsc_pkg::CODE_TURN;
                  nxt_cnt = rsc_pkg::TX2RX_CYC[14:0];
               end
            end
         endcase
      end
      // Shutting down to idle, with or without a calibration on the way.
      if (go_stop) begin
         nxt_state = rsc_pkg::RSC_WAIT;
         nxt_dest = rsc_pkg::RSC_IDLE;
         nxt_cal = stop_cal;
         nxt_code = stop_cal ? rsc_pkg::CODE_CAL : rsc_pkg::CODE_STOP;
         nxt_cnt = stop_cal ? CAL_CYC[14:0]
                            : rsc_pkg::OFF_CYC[14:0];
         if (i_cfg.synth_autocal_select == rsc_pkg::CAL_FOURTH) begin
            nxt_fourth = fourth_ff + 2'h1;
         end
      end
   end

   // State registers.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_ff <= rsc_pkg::RSC_IDLE;
         dest_ff <= rsc_pkg::RSC_IDLE;
         cnt_ff <= '0;
         code_ff <= rsc_pkg::CODE_IDLE;
         fourth_ff <= 2'h0;
         cal_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         dest_ff <= nxt_dest;
         cnt_ff <= nxt_cnt;
         code_ff <= nxt_code;
         fourth_ff <= nxt_fourth;
         cal_ff <= nxt_cal;
      end
   end

   // Outputs are decoded from registers only, so they never glitch.
   assign o_radio_state_readback = code_ff;
   assign o_rx_on = state_ff == rsc_pkg::RSC_RX;
   assign o_tx_on = state_ff == rsc_pkg::RSC_TX;
   assign o_synth_on = state_ff == rsc_pkg::RSC_SYNTH ||
                       state_ff == rsc_pkg::RSC_RX ||
                       state_ff == rsc_pkg::RSC_TX;
   assign o_cal_busy = cal_ff;

   // Checks on the sequencing. Each property names its clock and reset,
   // so a reset pulse abandons any check that is in flight.
   sequence wait_end_s;
      state_ff == rsc_pkg::RSC_WAIT && cnt_ff == CNT_ONE && !s_idle;
   endsequence

   sequence rx_start_s;
      state_ff == rsc_pkg::RSC_IDLE && s_rx;
   endsequence

   // Idle strobe in receive or transmit, which takes the stop path.
   sequence stop_req_s;
      (state_ff == rsc_pkg::RSC_RX || state_ff == rsc_pkg::RSC_TX)
      && s_idle;
   endsequence

   wait_expiry_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      wait_end_s |=> state_ff == $past(dest_ff))
      else $error("Wait did not land on its destination.");
   idle_force_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      s_idle && state_ff != rsc_pkg::RSC_RX && state_ff != rsc_pkg::RSC_TX
      |=> state_ff == rsc_pkg::RSC_IDLE
      && o_radio_state_readback == rsc_pkg::CODE_IDLE)
      else $error("Idle strobe not honoured.");
   rx_cal_start_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      rx_start_s ##0 (i_cfg.synth_autocal_select == rsc_pkg::CAL_ON_START)
      |=> cnt_ff == ON_CAL_CYC[14:0] && dest_ff == rsc_pkg::RSC_RX
      && o_cal_busy)
      else $error("Calibrated start delay wrong.");
   rx_plain_start_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      rx_start_s ##0 (i_cfg.synth_autocal_select != rsc_pkg::CAL_ON_START)
      |=> cnt_ff == rsc_pkg::ON_CYC[14:0])
      else $error("Plain start delay wrong.");
   tx_abort_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_TX && s_rx && !s_idle
      |=> cnt_ff == rsc_pkg::TX2RX_CYC[14:0] &&
          dest_ff == rsc_pkg::RSC_RX)
      else $error("Receive strobe did not end transmit.");
   cca_block_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_RX && (s_tx || s_syn) && !cca_ok
      && !i_stat.pkt_received && !i_stat.rx_timeout
      |=> state_ff == rsc_pkg::RSC_RX)
      else $error("Transmit entered on busy channel.");
   timeout_idle_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_RX && i_stat.rx_timeout && !i_strobe_valid
      && !i_stat.pkt_received
      |=> dest_ff == rsc_pkg::RSC_IDLE ##1 !o_rx_on)
      else $error("Timeout did not head to idle.");
   manual_cal_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_IDLE && s_cal
      |=> cnt_ff == CAL_CYC[14:0] && o_cal_busy
      && o_radio_state_readback == rsc_pkg::CODE_CAL)
      else $error("Manual calibration not started.");
   tx_hold_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_TX && !i_strobe_valid && !i_stat.pkt_sent
      |=> state_ff == rsc_pkg::RSC_TX)
      else $error("Transmit left before packet end.");
   readback_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_RX
      |-> o_radio_state_readback == rsc_pkg::CODE_RX)
      else $error("Readback does not show receive.");
   stop_plain_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      stop_req_s ##0 !stop_cal
      |=> cnt_ff == rsc_pkg::OFF_CYC[14:0] && dest_ff == rsc_pkg::RSC_IDLE
      && o_radio_state_readback == rsc_pkg::CODE_STOP)
      else $error("Plain stop delay wrong.");
   stop_cal_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      stop_req_s ##0 stop_cal
      |=> cnt_ff == CAL_CYC[14:0] && o_cal_busy
      && o_radio_state_readback == rsc_pkg::CODE_CAL)
      else $error("Calibrating stop delay wrong.");
   turn_tx_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_RX && s_tx && cca_ok
      |=> cnt_ff == rsc_pkg::RX2TX_CYC[14:0] && dest_ff == rsc_pkg::RSC_TX)
      else $error("Receive to transmit turnaround wrong.");
   synth_tx_a: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      state_ff == rsc_pkg::RSC_SYNTH && s_tx
      |=> o_tx_on && o_synth_on)
      else $error("Transmit strobe did not start from synth-on.");
endmodule : rsc_ctrl

/* File: dv/radio_state_controller_tb_top.sv */
`timescale 1ns/1ps
module radio_state_controller_tb_top;
   // Calibration counts are shortened; every calibration expectation derives from them.
   localparam int CAL_N = 40;
   localparam int ON_CAL_N = 50;
   localparam int LIMIT = 80000;
   localparam logic [4:0] IDL = rsc_pkg::CODE_IDLE;
   localparam logic [4:0] STA = rsc_pkg::CODE_START;
   localparam logic [4:0] CAL = rsc_pkg::CODE_CAL;
   localparam logic [4:0] STP = rsc_pkg::CODE_STOP;
   localparam logic [4:0] RXS = rsc_pkg::CODE_RX;
   localparam logic [4:0] SYN = rsc_pkg::CODE_SYNTH;
   localparam logic [4:0] TXS = rsc_pkg::CODE_TX;
   localparam logic [4:0] TRN = rsc_pkg::CODE_TURN;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_strobe_valid = 1'b0;
   logic [7:0] i_radio_strobe_register = 8'h00;
   rsc_pkg::rsc_cfg_t i_cfg = '0;
   rsc_pkg::rsc_stat_t i_stat = '0;
   logic [4:0] o_radio_state_readback;
   logic o_rx_on;
   logic o_tx_on;
   logic o_synth_on;
   logic o_cal_busy;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;

   rsc_ctrl #(.CAL_CRYSTAL_OSCILLATOR(CAL_N), .ON_CAL_CRYSTAL_OSCILLATOR(ON_CAL_N)) dut_u (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_strobe_valid(i_strobe_valid),
      .i_radio_strobe_register(i_radio_strobe_register),
      .i_cfg(i_cfg),
      .i_stat(i_stat),
      .o_radio_state_readback(o_radio_state_readback),
      .o_rx_on(o_rx_on),
      .o_tx_on(o_tx_on),
      .o_synth_on(o_synth_on),
      .o_cal_busy(o_cal_busy)
   );

   // Free-running crystal clock, one period per crystal cycle.
   initial begin
      forever #4 i_ref_clk = ~i_ref_clk;
   end

   // Watchdog so a stuck wait state cannot hang the run.
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (err_total == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic cmp5(input string nm, input logic [4:0] e,
                       input logic [4:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp5

   task automatic cmp1(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp1

   // Expected level outputs {rx, tx, synth} for a settled state code.
   function automatic logic [2:0] flags(input logic [4:0] s);
      flags = {s == RXS, s == TXS, (s == RXS) || (s == TXS) || (s == SYN)};
   endfunction : flags

   // Delay after a packet ends; zero means the move is immediate.
   function automatic int after_n(input bit from_rx, input logic [1:0] a);
      case (a)
         rsc_pkg::OFF_IDLE: after_n = rsc_pkg::OFF_CYC;
         rsc_pkg::OFF_RX: after_n = from_rx ? 0 : rsc_pkg::TX2RX_CYC;
         default: after_n = from_rx ? rsc_pkg::RX2TX_CYC : 0;
      endcase
   endfunction : after_n

   function automatic logic [4:0] after_d(input logic [1:0] a);
      case (a)
         rsc_pkg::OFF_IDLE: after_d = IDL;
         rsc_pkg::OFF_SYNTH: after_d = SYN;
         rsc_pkg::OFF_TX: after_d = TXS;
         default: after_d = RXS;
      endcase
   endfunction : after_d

   function automatic logic [4:0] wcode(input int n);
      wcode = (n == rsc_pkg::OFF_CYC) ? STP : TRN;
   endfunction : wcode

   // Clear-channel verdict for each mode.
   function automatic bit clear(input logic [1:0] m, input bit rb,
                                input bit rc);
      case (m)
         rsc_pkg::CCA_ALWAYS: clear = 1'b1;
         rsc_pkg::CCA_RSSI: clear = rb;
         rsc_pkg::CCA_NO_PKT: clear = !rc;
         default: clear = rb && !rc;
      endcase
   endfunction : clear

   task automatic chk_dst(input logic [4:0] s);
      logic [2:0] f;
      f = flags(s);
      cmp5("readback", s, o_radio_state_readback);
      cmp1("rx_on", f[2], o_rx_on);
      cmp1("tx_on", f[1], o_tx_on);
      cmp1("synth_on", f[0], o_synth_on);
      cmp1("cal_busy", 1'b0, o_cal_busy);
   endtask : chk_dst

   // Kind 0 writes a strobe code; 1..3 pulse received, sent, timeout.
   task automatic pulse(input int kind, input logic [7:0] c);
      @(posedge i_ref_clk);
      i_strobe_valid <= (kind == 0);
      i_radio_strobe_register <= c;
      i_stat.pkt_received <= (kind == 1);
      i_stat.pkt_sent <= (kind == 2);
      i_stat.rx_timeout <= (kind == 3);
      @(posedge i_ref_clk);
      i_strobe_valid <= 1'b0;
      i_stat.pkt_received <= 1'b0;
      i_stat.pkt_sent <= 1'b0;
      i_stat.rx_timeout <= 1'b0;
   endtask : pulse

   // A wait of n cycles is entered at the taking edge and still shows
   // n-1 edges later; the destination appears at the nth edge. A
   // calibrating start shows the starting code with the busy flag up.
   task automatic move(input int kind, input logic [7:0] c, input int n,
                       input logic [4:0] w, input logic [4:0] d);
      pulse(kind, c);
      if (n > 0) begin
         repeat (n - 1) @(posedge i_ref_clk);
         #1 cmp5("wait_code", w, o_radio_state_readback);
         cmp1("wait_cal", (w == CAL) || (w == STA && n == ON_CAL_N),
              o_cal_busy);
      end
      @(posedge i_ref_clk);
      #1 chk_dst(d);
   endtask : move

   task automatic rst();
      @(posedge i_ref_clk);
      i_srst <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      #1 chk_dst(IDL);
   endtask : rst

   task automatic go(input logic [7:0] c, input logic [4:0] d);
      rst();
      move(0, c, rsc_pkg::ON_CYC, STA, d);
   endtask : go

   // Main sequence: directed corners mixed with random channel states.
   initial begin
      int n;
      bit rb;
      bit rc;
      logic [7:0] c;
      void'($urandom(37));
      for (int a = 0; a < 4; a++) begin
         @(posedge i_ref_clk);
         i_cfg.after_receive_state <= a[1:0];
         i_cfg.after_transmit_state <= a[1:0];
         go(rsc_pkg::STB_RECEIVE, RXS);
         n = after_n(1'b1, a[1:0]);
         move(1, 8'h00, n, wcode(n), after_d(a[1:0]));
         go(rsc_pkg::STB_TRANSMIT, TXS);
         n = after_n(1'b0, a[1:0]);
         move(2, 8'h00, n, wcode(n), after_d(a[1:0]));
      end
      go(rsc_pkg::STB_TRANSMIT, TXS);
      move(0, rsc_pkg::STB_RECEIVE, rsc_pkg::TX2RX_CYC, TRN, RXS);
      move(0, rsc_pkg::STB_CALIBRATE, 0, IDL, RXS);
      move(0, rsc_pkg::STB_GO_IDLE, rsc_pkg::OFF_CYC, STP, IDL);
      move(0, rsc_pkg::STB_CALIBRATE, CAL_N, CAL, IDL);
      move(0, rsc_pkg::STB_SYNTH_ON, rsc_pkg::ON_CYC, STA, SYN);
      move(0, rsc_pkg::STB_TRANSMIT, 0, IDL, TXS);
      move(0, rsc_pkg::STB_GO_IDLE, rsc_pkg::OFF_CYC, STP, IDL);
      pulse(0, rsc_pkg::STB_RECEIVE);
      repeat (10) @(posedge i_ref_clk);
      move(0, rsc_pkg::STB_GO_IDLE, 0, IDL, IDL);
      @(posedge i_ref_clk);
      i_cfg.after_receive_state <= rsc_pkg::OFF_SYNTH;
      go(rsc_pkg::STB_RECEIVE, RXS);
      move(3, 8'h00, rsc_pkg::OFF_CYC, STP, IDL);
      // First two rounds are fixed: busy channel, always versus signal.
      for (int i = 0; i < 6; i++) begin
         rb = (i >= 2) ? 1'($urandom) : 1'b0;
         rc = (i >= 2) ? 1'($urandom) : 1'b1;
         c = i[0] ? rsc_pkg::STB_SYNTH_ON : rsc_pkg::STB_TRANSMIT;
         @(posedge i_ref_clk);
         i_cfg.clear_channel_mode <= i[1:0];
         i_stat.rssi_below <= rb;
         i_stat.receiving <= rc;
         go(rsc_pkg::STB_RECEIVE, RXS);
         if (clear(i[1:0], rb, rc)) begin
            move(0, c, rsc_pkg::RX2TX_CYC, TRN, i[0] ? SYN : TXS);
         end else begin
            move(0, c, 0, IDL, RXS);
         end
      end
      // The controller calibrates the synthesizer itself through these modes.
      @(posedge i_ref_clk);
      i_cfg.synth_autocal_select <= rsc_pkg::CAL_ON_START;
      rst();
      move(0, rsc_pkg::STB_RECEIVE, ON_CAL_N, STA, RXS);
      @(posedge i_ref_clk);
      i_cfg.synth_autocal_select <= rsc_pkg::CAL_ON_STOP;
      move(0, rsc_pkg::STB_GO_IDLE, CAL_N, CAL, IDL);
      @(posedge i_ref_clk);
      i_cfg.synth_autocal_select <= rsc_pkg::CAL_FOURTH;
      rst();
      for (int k = 0; k < 4; k++) begin
         move(0, rsc_pkg::STB_RECEIVE, rsc_pkg::ON_CYC, STA, RXS);
         n = (k == 3) ? CAL_N : rsc_pkg::OFF_CYC;
         move(0, rsc_pkg::STB_GO_IDLE, n, (k == 3) ? CAL : STP, IDL);
      end
      stop_test();
   end
endmodule : radio_state_controller_tb_top
